//--- core/tlagc_pkg.sv
package tlagc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] REG_TEMP_MSB = 8'h00;
    localparam logic [7:0] REG_TEMP_LSB = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_CONFIG = 8'h03;
    localparam logic [7:0] REG_UPPER_MSB = 8'h04;
    localparam logic [7:0] REG_UPPER_LSB = 8'h05;
    localparam logic [7:0] REG_LOWER_MSB = 8'h06;
    localparam logic [7:0] REG_LOWER_LSB = 8'h07;
    localparam logic [7:0] REG_CRIT_MSB = 8'h08;
    localparam logic [7:0] REG_CRIT_LSB = 8'h09;
    localparam logic [7:0] REG_HYST = 8'h0A;
    localparam logic [7:0] REG_IDENT = 8'h0B;

    // ************************************************************
    // Bus addressing
    // ************************************************************
    localparam logic [4:0] DEV_ADDR_BASE = 5'h12;
    localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
    localparam logic [7:0] GC_RESET_CMD = 8'h06;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int CFG_CT_POL_BIT = 2;
    localparam int CFG_INT_POL_BIT = 3;
    localparam int CFG_CMP_MODE_BIT = 4;
    localparam int CFG_OP_LSB = 5;
    localparam logic [1:0] OP_SHUTDOWN = 2'h3;
    localparam int STAT_LOW_BIT = 4;
    localparam int STAT_HIGH_BIT = 5;
    localparam int STAT_CRIT_BIT = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [3:0] HYST_RESET = 4'h5;
    localparam int HYST_SHIFT = 7;
    localparam logic [15:0] UPPER_RESET = 16'h2000;
    localparam logic [15:0] LOWER_RESET = 16'h0500;
    localparam logic [15:0] CRIT_RESET = 16'h4000;
    // Arbitrary identification value
    localparam logic [7:0] IDENT_VALUE = 8'h5A;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int RESET_TIME_US = 200;
    localparam int CLK_MHZ = 250;
    localparam int RESET_CYCLES = RESET_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_GCMD, ST_READ, ST_RACK, ST_IGNORE
    } tlagc_state_e;

endpackage

//--- core/tlagc_core.sv
`timescale 1ns/1ps

// Contract
// - Acknowledge general call, then take command byte
// - Command 0x06 reloads every register default except temperature, which keeps its value
// - No acknowledge during 200 us reload
// - Other general call commands left unacknowledged
// - Interrupt mode selected after power-up
// - Alarm when above upper or below lower
// - Comparator mode releases past hysteresis band
// - Comparator mode: shutdown keeps alarm state
// - Interrupt mode: any register read clears alarm
// - Interrupt mode: re-arms only on new violation
// - Interrupt mode: shutdown clears alarm
// - Continuous conversion after power-up
// - Read-only identification register at 0x0B
// - Configuration and limit registers at fixed addresses
// - Alarm outputs open-drain, never drive high
// - Four-bit hysteresis, default five degrees
module tlagc_core #(
    parameter int RESET_CYCLES = tlagc_pkg::RESET_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic link_scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [1:0] addr_sel_in,
    input wire logic [15:0] temp_result_in,
    input wire logic temp_valid_in,
    output logic conv_run_out,
    output logic int_pin_out,
    output logic int_oe_out,
    output logic critical_alarm_out,
    output logic critical_alarm_oe_out
);
    import tlagc_pkg::*;

    localparam int CW = $clog2(RESET_CYCLES + 1);

    // ************************************************************
    // Link domain: bit shifter on the bus clock
    // ************************************************************
    logic frame_rst_q;
    logic link_rst_n;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] rx_byte_q;
    logic rx_tog_q;

    // Released while the bus clock is low, so no edge races it
    assign link_rst_n = arst_n_in & ~frame_rst_q;

    always_ff @(posedge link_scl_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 4'h0;
        end else if (bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Kept out of the frame reset so the toggle never fakes a byte
    always_ff @(posedge link_scl_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_q <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_tog_q <= 1'b0;
        end else begin
            shift_q <= {shift_q[6:0], sda_in};
            if (bit_cnt_q == 4'h7) begin
                rx_byte_q <= {shift_q[6:0], sda_in};
                rx_tog_q <= ~rx_tog_q;
            end
        end
    end

    // ************************************************************
    // Synchronisers into the reference domain
    // ************************************************************
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic tog_m_q, tog_s_q, tog_p_q;
    logic [1:0] asel_m_q, asel_s_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            tog_m_q <= 1'b0;
            tog_s_q <= 1'b0;
            tog_p_q <= 1'b0;
            asel_m_q <= 2'h0;
            asel_s_q <= 2'h0;
        end else begin
            scl_m_q <= link_scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            tog_m_q <= rx_tog_q;
            tog_s_q <= tog_m_q;
            tog_p_q <= tog_s_q;
            asel_m_q <= addr_sel_in;
            asel_s_q <= asel_m_q;
        end
    end

    logic start_p, stop_p, fall_p, rise_p, byte_p;
    assign start_p = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_p = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign fall_p = scl_p_q & ~scl_s_q;
    assign rise_p = ~scl_p_q & scl_s_q;
    // Byte word is stable for nine bus clocks after its toggle
    assign byte_p = tog_s_q ^ tog_p_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frame_rst_q <= 1'b0;
        end else if (start_p) begin
            frame_rst_q <= 1'b1;
        end else if (!scl_s_q) begin
            frame_rst_q <= 1'b0;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] cfg_q;
    logic [15:0] upper_limit_q, lower_limit_q, critical_limit_q, temp_q;
    logic [3:0] hysteresis_value_q;
    logic [7:0] ptr_q;
    logic off_q;
    logic [7:0] eff_addr;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic cmp_hi_q, cmp_lo_q, crit_act_q;

    assign eff_addr = ptr_q + {7'h00, off_q};
    assign status_byte = {1'b0, crit_act_q, cmp_hi_q, cmp_lo_q, 4'h0};

    function automatic logic pair_msb(input logic [7:0] a);
        pair_msb = (a == REG_TEMP_MSB) || (a == REG_UPPER_MSB) ||
                   (a == REG_LOWER_MSB) || (a == REG_CRIT_MSB);
    endfunction

    always_comb begin
        unique case (eff_addr)
            REG_TEMP_MSB: rd_byte = temp_q[15:8];
            REG_TEMP_LSB: rd_byte = temp_q[7:0];
            REG_STATUS: rd_byte = status_byte;
            REG_CONFIG: rd_byte = cfg_q;
            REG_UPPER_MSB: rd_byte = upper_limit_q[15:8];
            REG_UPPER_LSB: rd_byte = upper_limit_q[7:0];
            REG_LOWER_MSB: rd_byte = lower_limit_q[15:8];
            REG_LOWER_LSB: rd_byte = lower_limit_q[7:0];
            REG_CRIT_MSB: rd_byte = critical_limit_q[15:8];
            REG_CRIT_LSB: rd_byte = critical_limit_q[7:0];
            REG_HYST: rd_byte = {4'h0, hysteresis_value_q};
            REG_IDENT: rd_byte = IDENT_VALUE;
            default: rd_byte = 8'h00;
        endcase
    end

    // ************************************************************
    // Bus protocol
    // ************************************************************
    tlagc_state_e state_q, ack_next_q;
    logic sda_oe_q, ack_drv_q, ptr_set_q, wr_done_q, gc_rst_q;
    logic [7:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic [CW-1:0] busy_cnt_q;
    logic busy;
    logic ld_p, wr_p, gc_load_p;

    assign busy = busy_cnt_q != '0;
    assign ld_p = fall_p && (((state_q == ST_ACK) && ack_drv_q && (ack_next_q == ST_READ)) ||
                             ((state_q == ST_READ) && (tx_cnt_q == 4'h0)));
    assign wr_p = byte_p && (state_q == ST_WRITE) && ptr_set_q && !wr_done_q;
    assign gc_load_p = fall_p && (state_q == ST_ACK) && ack_drv_q && gc_rst_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
            ack_next_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
            ack_drv_q <= 1'b0;
            ptr_set_q <= 1'b0;
            wr_done_q <= 1'b0;
            gc_rst_q <= 1'b0;
            ptr_q <= REG_TEMP_MSB;
            off_q <= 1'b0;
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 4'h0;
        end else if (start_p) begin
            state_q <= ST_ADDR;
            sda_oe_q <= 1'b0;
            ack_drv_q <= 1'b0;
            ptr_set_q <= 1'b0;
            wr_done_q <= 1'b0;
            gc_rst_q <= 1'b0;
            off_q <= 1'b0;
        end else if (stop_p) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
            ack_drv_q <= 1'b0;
        end else begin
            if (ld_p) begin
                // Two-byte registers step MSB to LSB once
                if (pair_msb(ptr_q) && !off_q) begin
                    off_q <= 1'b1;
                end
                sda_oe_q <= ~rd_byte[7];
                tx_sh_q <= {rd_byte[6:0], 1'b0};
                tx_cnt_q <= 4'h1;
            end
            if (gc_load_p) begin
                ptr_q <= REG_TEMP_MSB;
            end
            unique case (state_q)
                ST_IDLE, ST_IGNORE: begin
                end
                ST_ADDR: begin
                    if (byte_p) begin
                        if (busy) begin
                            state_q <= ST_IGNORE;
                        end else if (rx_byte_q == GC_ADDR_BYTE) begin
                            state_q <= ST_ACK;
                            ack_next_q <= ST_GCMD;
                        end else if (rx_byte_q[7:1] == {DEV_ADDR_BASE, asel_s_q}) begin
                            state_q <= ST_ACK;
                            ack_next_q <= rx_byte_q[0] ? ST_READ : ST_WRITE;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                end
                ST_GCMD: begin
                    if (byte_p) begin
                        if (rx_byte_q == GC_RESET_CMD) begin
                            state_q <= ST_ACK;
                            ack_next_q <= ST_IDLE;
                            gc_rst_q <= 1'b1;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (byte_p) begin
                        state_q <= ST_ACK;
                        ack_next_q <= ST_WRITE;
                        if (!ptr_set_q) begin
                            ptr_q <= rx_byte_q;
                            ptr_set_q <= 1'b1;
                        end else if (!wr_done_q) begin
                            // Surplus bytes are acknowledged and dropped
                            if (pair_msb(ptr_q) && !off_q) begin
                                off_q <= 1'b1;
                            end else begin
                                wr_done_q <= 1'b1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (fall_p) begin
                        if (!ack_drv_q) begin
                            sda_oe_q <= 1'b1;
                            ack_drv_q <= 1'b1;
                        end else begin
                            ack_drv_q <= 1'b0;
                            state_q <= ack_next_q;
                            if (ack_next_q != ST_READ) begin
                                sda_oe_q <= 1'b0;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (fall_p && (tx_cnt_q == 4'h8)) begin
                        sda_oe_q <= 1'b0;
                        tx_cnt_q <= 4'h0;
                        state_q <= ST_RACK;
                    end else if (fall_p && (tx_cnt_q != 4'h0)) begin
                        sda_oe_q <= ~tx_sh_q[7];
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (rise_p) begin
                        state_q <= sda_s_q ? ST_IGNORE : ST_READ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_cnt_q <= '0;
        end else if (gc_load_p) begin
            busy_cnt_q <= CW'(RESET_CYCLES);
        end else if (busy) begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_q <= CFG_RESET;
            upper_limit_q <= UPPER_RESET;
            lower_limit_q <= LOWER_RESET;
            critical_limit_q <= CRIT_RESET;
            hysteresis_value_q <= HYST_RESET;
        end else if (gc_load_p) begin
            cfg_q <= CFG_RESET;
            upper_limit_q <= UPPER_RESET;
            lower_limit_q <= LOWER_RESET;
            critical_limit_q <= CRIT_RESET;
            hysteresis_value_q <= HYST_RESET;
        end else if (wr_p) begin
            unique case (eff_addr)
                REG_CONFIG: cfg_q <= rx_byte_q;
                REG_UPPER_MSB: upper_limit_q[15:8] <= rx_byte_q;
                REG_UPPER_LSB: upper_limit_q[7:0] <= rx_byte_q;
                REG_LOWER_MSB: lower_limit_q[15:8] <= rx_byte_q;
                REG_LOWER_LSB: lower_limit_q[7:0] <= rx_byte_q;
                REG_CRIT_MSB: critical_limit_q[15:8] <= rx_byte_q;
                REG_CRIT_LSB: critical_limit_q[7:0] <= rx_byte_q;
                REG_HYST: hysteresis_value_q <= rx_byte_q[3:0];
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Limit comparison and alarm outputs
    // ************************************************************
    logic shdn, shdn_prev_q, shdn_rise, cmp_mode, res_p;
    logic over, under, below_hi, above_lo, crit_over, crit_below;
    logic int_evt_q, alarm_act, int_oe_q, ct_oe_q, conv_run_q;
    logic signed [17:0] t_s, up_s, lo_s, cr_s, hy_s;

    assign shdn = cfg_q[CFG_OP_LSB +: 2] == OP_SHUTDOWN;
    assign shdn_rise = shdn && !shdn_prev_q;
    assign cmp_mode = cfg_q[CFG_CMP_MODE_BIT];
    assign res_p = temp_valid_in && !shdn;
    assign t_s = {{2{temp_result_in[15]}}, temp_result_in};
    assign up_s = {{2{upper_limit_q[15]}}, upper_limit_q};
    assign lo_s = {{2{lower_limit_q[15]}}, lower_limit_q};
    assign cr_s = {{2{critical_limit_q[15]}}, critical_limit_q};
    assign hy_s = 18'(hysteresis_value_q) <<< HYST_SHIFT;
    assign over = t_s > up_s;
    assign under = t_s < lo_s;
    assign below_hi = t_s < (up_s - hy_s);
    assign above_lo = t_s > (lo_s + hy_s);
    assign crit_over = t_s > cr_s;
    assign crit_below = t_s < (cr_s - hy_s);
    assign alarm_act = cmp_mode ? (cmp_hi_q | cmp_lo_q) : int_evt_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            temp_q <= 16'h0000;
            cmp_hi_q <= 1'b0;
            cmp_lo_q <= 1'b0;
            crit_act_q <= 1'b0;
        end else if (gc_load_p) begin
            cmp_hi_q <= 1'b0;
            cmp_lo_q <= 1'b0;
            crit_act_q <= 1'b0;
        end else if (res_p) begin
            temp_q <= temp_result_in;
            cmp_hi_q <= over | (cmp_hi_q & ~below_hi);
            cmp_lo_q <= under | (cmp_lo_q & ~above_lo);
            crit_act_q <= crit_over | (crit_act_q & ~crit_below);
        end
    end

    // Event set wins over a read or shutdown clear
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            int_evt_q <= 1'b0;
        end else if (gc_load_p) begin
            int_evt_q <= 1'b0;
        end else if (res_p && (over || under)) begin
            int_evt_q <= 1'b1;
        end else if (!cmp_mode && (ld_p || shdn_rise)) begin
            int_evt_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shdn_prev_q <= 1'b0;
            int_oe_q <= 1'b0;
            ct_oe_q <= 1'b0;
            conv_run_q <= 1'b0;
        end else begin
            shdn_prev_q <= shdn;
            // Pull low only; polarity decides which state pulls
            int_oe_q <= cfg_q[CFG_INT_POL_BIT] ^ alarm_act;
            ct_oe_q <= cfg_q[CFG_CT_POL_BIT] ^ crit_act_q;
            conv_run_q <= ~shdn;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_q;
    assign int_pin_out = 1'b0;
    assign int_oe_out = int_oe_q;
    assign critical_alarm_out = 1'b0;
    assign critical_alarm_oe_out = ct_oe_q;
    assign conv_run_out = conv_run_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    AST_GC_ACK: assert property (
        state_q == ST_ADDR && byte_p && !busy && rx_byte_q == GC_ADDR_BYTE && !start_p && !stop_p
        |=> state_q == ST_ACK && ack_next_q == ST_GCMD)
        else $error("general call address not acknowledged");
    AST_GC_LOAD: assert property (
        gc_load_p |=> cfg_q == CFG_RESET && upper_limit_q == UPPER_RESET && busy)
        else $error("reset command did not reload defaults");
    AST_BUSY_SILENT: assert property (
        busy |-> !sda_oe_q)
        else $error("bus driven during default reload");
    AST_GC_OTHER: assert property (
        state_q == ST_GCMD && byte_p && rx_byte_q != GC_RESET_CMD && !start_p && !stop_p
        |=> state_q == ST_IGNORE ##1 !sda_oe_q)
        else $error("unknown general call command acted on");
    AST_MODE_DEFAULT: assert property (
        gc_load_p |=> !cmp_mode ##1 !cmp_mode || wr_p)
        else $error("interrupt mode not default");
    AST_ALARM_SET: assert property (
        res_p && (over || under) && !gc_load_p && !wr_p |=> alarm_act)
        else $error("alarm not raised on limit violation");
    AST_CMP_CLEAR: assert property (
        cmp_mode && res_p && below_hi && above_lo && !over && !under && !gc_load_p && !wr_p
        |=> !alarm_act)
        else $error("comparator alarm not released");
    AST_CMP_SHDN: assert property (
        cmp_mode && shdn_rise && !gc_load_p && !wr_p |=> alarm_act == $past(alarm_act))
        else $error("shutdown changed comparator alarm");
    AST_READ_CLEAR: assert property (
        !cmp_mode && ld_p && !(res_p && (over || under)) && !gc_load_p |=> !alarm_act)
        else $error("register read did not clear alarm");
    AST_NO_REARM: assert property (
        !cmp_mode && !alarm_act && !(res_p && (over || under)) && !wr_p |=> !alarm_act)
        else $error("alarm re-armed without violation");
    AST_SHDN_CLEAR: assert property (
        !cmp_mode && shdn_rise && !gc_load_p && !wr_p |=> !alarm_act)
        else $error("shutdown did not clear alarm");
    AST_CONT_RUN: assert property (
        gc_load_p |=> ##1 conv_run_out)
        else $error("conversions not running after reset");
    AST_IDENT: assert property (
        ld_p && eff_addr == REG_IDENT && !start_p && !stop_p |=> sda_oe_q == ~IDENT_VALUE[7])
        else $error("identification value not sent");
    AST_OD_POL: assert property (
        1'b1 |=> int_oe_out == ($past(cfg_q[CFG_INT_POL_BIT]) ^ $past(alarm_act)))
        else $error("alarm pin drive wrong for polarity");
    AST_HYST_WR: assert property (
        wr_p && eff_addr == REG_HYST |=> hysteresis_value_q == $past(rx_byte_q[3:0]))
        else $error("hysteresis write lost");
    AST_RES_STORE: assert property (
        res_p && !gc_load_p |=> temp_q == $past(temp_result_in))
        else $error("result not stored");

endmodule

//--- verification/tlagc_i2c_master.sv
`timescale 1ns/1ps
module tlagc_i2c_master (
    input wire logic sda_oe_in,
    output logic scl_out,
    output logic sda_out
);
    logic lclk = 1'b0, pull = 1'b0;
    // Pull-up: a released line reads high
    assign sda_out = ~(pull | sda_oe_in);
    initial begin
        scl_out = 1'b1;
        #7.3;
        forever #16 lclk = ~lclk;
    end
    // Start is (0, 1), stop is (1, 0); SCL stands high between frames
    task automatic cond(input logic x, input logic y);
        @(posedge lclk) pull = x;
        @(posedge lclk) scl_out = 1'b1;
        @(posedge lclk) pull = y;
        @(posedge lclk) scl_out = ~y;
    endtask
    // SDA moves mid-low only; ninth bit released for ack or nack
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic [8:0] sh;
        sh = {d, 1'b1};
        repeat (9) begin
            @(posedge lclk) pull = ~sh[8];
            @(posedge lclk) scl_out = 1'b1;
            @(posedge lclk) sh = {sh[7:0], sda_out};
            @(posedge lclk) scl_out = 1'b0;
        end
        {q, ack} = {sh[8:1], ~sh[0]};
    endtask
endmodule

//--- verification/temp_limit_alarm_general_call_tb_top.sv
`timescale 1ns/1ps
module temp_limit_alarm_general_call_tb_top;
    import tlagc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, tv = 1'b0;
    logic [15:0] tr = 16'h0000;
    logic [1:0] sel;
    logic [7:0] q;
    logic scl, sda, sdo, sda_oe, run, ip, ioe, ca, ca_oe, a;
    int n_errors = 0, n_compared = 0, seed = 32'h691f4bce;
    int up = UPPER_RESET, lo = LOWER_RESET, cr = CRIT_RESET, h = 128 * HYST_RESET;
    // Latched flag, upper/lower/critical flags, mode, polarities, shutdown
    bit fi, fh, fl, fk, cm, pol, cpol, sd;
    always #2 clk = ~clk;
    tlagc_core #(.RESET_CYCLES(2000)) dut (.ref_clk_in(clk), .arst_n_in(rst_n),
        .link_scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe_out(sda_oe),
        .addr_sel_in(sel), .temp_result_in(tr), .temp_valid_in(tv), .conv_run_out(run),
        .int_pin_out(ip), .int_oe_out(ioe), .critical_alarm_out(ca), .critical_alarm_oe_out(ca_oe));
    tlagc_i2c_master mst (.sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        n_errors += (s !== e);
        if (s !== e) $display("unexpected %s: exp %h seen %h", nm, e, s);
    endtask
    task automatic pin();
        chk("pins", {2'h0, !sd, fk ^ cpol, 3'h0, (cm ? fh || fl : fi) ^ pol},
            {2'h0, run, ca_oe, sdo, ip, ca, ioe});
    endtask
    task automatic adr(input logic rw);
        mst.cond(1'b0, 1'b1);
        mst.xfer({DEV_ADDR_BASE, sel, rw}, q, a);
    endtask
    task automatic acc(input logic r, input logic [7:0] p, input logic [7:0] d);
        adr(1'b0);
        mst.xfer(p, q, a);
        if (r) adr(1'b1);
        mst.xfer(r ? 8'hFF : d, q, a);
        mst.cond(1'b1, 1'b0);
        if (r) chk("reg", d, q);
        if (r) fi = fi && cm;
        if (!r && p == REG_HYST) h = 128 * d[3:0];
        if (!r && p == REG_CONFIG) begin
            fi = fi && (d[CFG_CMP_MODE_BIT] || sd || d[CFG_OP_LSB +: 2] != OP_SHUTDOWN);
            sd = d[CFG_OP_LSB +: 2] == OP_SHUTDOWN;
            {cpol, pol, cm} = {d[CFG_CT_POL_BIT], d[CFG_INT_POL_BIT], d[CFG_CMP_MODE_BIT]};
        end
        pin();
    endtask
    task automatic temp(input int v);
        @(posedge clk) #1 {tr, tv} = {v[15:0], 1'b1};
        @(posedge clk) #1 tv = 1'b0;
        fi = fi || v > up || v < lo;
        fh = v > up || (fh && v >= up - h);
        fl = v < lo || (fl && v <= lo + h);
        fk = v > cr || (fk && v >= cr - h);
        #12 pin();
    endtask
    task automatic gc(input logic [7:0] c);
        mst.cond(1'b0, 1'b1);
        mst.xfer(GC_ADDR_BYTE, q, a);
        chk("gc ack", 8'h01, {7'h00, a});
        mst.xfer(c, q, a);
        mst.cond(1'b1, 1'b0);
    endtask
    task automatic print_verdict(input int late);
        n_errors += late;
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole run needs about 0.063 ms
    initial #200000 print_verdict(1);
    initial begin
        sel = 2'($random(seed));
        #79 rst_n = 1'b1;
        #20 acc(1'b1, REG_IDENT, IDENT_VALUE);
        acc(1'b1, REG_UPPER_MSB, UPPER_RESET[15:8]);
        acc(1'b0, REG_HYST, 8'h03);
        acc(1'b1, REG_HYST, 8'h03);
        temp(up + 1 + ($random(seed) & 32'hFFF));
        temp(32'h1000);
        acc(1'b1, REG_TEMP_MSB, 8'h10);
        temp(32'h1000);
        temp(lo - 1);
        acc(1'b0, REG_CONFIG, 8'h60);
        acc(1'b0, REG_CONFIG, 8'h10);
        temp(cr + 1);
        temp(up - h / 2);
        acc(1'b0, REG_CONFIG, 8'h70);
        acc(1'b0, REG_CONFIG, 8'h18);
        temp(up - h - 1);
        gc(8'h07);
        chk("gc cmd ack", 8'h00, {7'h00, a});
        gc(GC_RESET_CMD);
        adr(1'b0);
        chk("busy ack", 8'h00, {7'h00, a});
        mst.cond(1'b1, 1'b0);
        repeat (2000) @(posedge clk);
        {fi, fh, fl, fk, cm, pol, cpol, sd} = 8'h00;
        h = 128 * HYST_RESET;
        acc(1'b1, REG_CONFIG, CFG_RESET);
        acc(1'b1, REG_HYST, {4'h0, HYST_RESET});
        print_verdict(0);
    end
endmodule
